// file: src/ccptr_top.sv
// Two capture/compare/PWM units with shared timers behind an AHB-Lite slave
//
// Our own choices: the AHB-Lite register port and the register addresses.
`include "ccptr_params.svh"
`default_nettype none
module ccptr_top (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    output logic [31:0]               hrdata_o,
    input  wire logic                 first_unit_pin_i,
    output logic                      first_unit_pin_o,
    output logic                      first_unit_pin_oe_o,
    input  wire logic                 port_c_line_one_i,
    output logic                      port_c_line_one_o,
    output logic                      port_c_line_one_oe_o,
    input  wire logic                 port_b_line_three_i,
    output logic                      port_b_line_three_o,
    output logic                      port_b_line_three_oe_o,
    input  wire logic                 first_timer_ext_clk_i,
    output logic                      adc_start_o,
    output logic                      second_timer_period_o
);
    import ccptr_pkg::*;

    // Bus state
    logic        rd_pend_r;
    logic        wr_pend_r;
    logic [7:0]  addr_r;
    logic        hreadyout_r;
    logic [31:0] hrdata_r;

    // Registers
    ccptr_byte_t unit_control_reg_r [2];
    ccptr_byte_t unit_data_low_r    [2];
    ccptr_byte_t unit_data_high_r   [2];
    ccptr_byte_t third_timer_control_r;
    ccptr_byte_t first_timer_ctrl_r;
    ccptr_byte_t second_timer_ctrl_r;
    ccptr_byte_t second_timer_period_r;
    ccptr_byte_t cfg_r;

    // Timers
    ccptr_word_t first_timer_r;
    ccptr_word_t third_timer_r;
    ccptr_byte_t second_timer_r;
    logic        t2_wrap_r;

    // Pin synchronisers: unit1 pin, port C line one, port B line three, ext clock
    logic [3:0]  pin_meta_r;
    logic [3:0]  pin_sync_r;
    logic [3:0]  pin_last_r;

    // Unit state
    logic [1:0]  match_r;
    logic [1:0]  sev_r;
    logic [1:0]  sev_third_r;
    logic [1:0]  out_r;
    logic [1:0]  oe_r;
    logic        adc_start_r;

    // Combinational helpers
    ccptr_class_t cls      [2];
    logic [1:0]   on_third;
    ccptr_word_t  tbase    [2];
    logic [1:0]   match_now;
    logic [1:0]   match_new;
    logic [1:0]   cap_evt;
    logic [1:0]   pin_in;
    logic         wr_go;
    logic         ext_edge;
    logic         pinsel;

    function automatic ccptr_class_t mode_class(input ccptr_byte_t ctrl);
        logic [3:0] m;
        m = ctrl[3:0];
        if (m[3:2] == 2'b11) begin
            return CCPTR_PWM;
        end else if (m == `CCPTR_MODE_CAPF || m == `CCPTR_MODE_CAPR) begin
            return CCPTR_CAPT;
        end else if (m == `CCPTR_MODE_CTOG || (m >= `CCPTR_MODE_CSET && m <= `CCPTR_MODE_CSEV)) begin
            return CCPTR_CMP;
        end
        return CCPTR_OFF;
    endfunction

    // Selection code: 00 both on first timer, 01 second unit on third, 1x both on third
    function automatic logic uses_third(input int unsigned u, input logic [1:0] sel);
        return (u == 0) ? sel[1] : (sel[1] | sel[0]);
    endfunction

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            `CCPTR_OFS_UCTRL0: d = {24'h00_0000, unit_control_reg_r[0]};
            `CCPTR_OFS_DLO0:   d = {24'h00_0000, unit_data_low_r[0]};
            `CCPTR_OFS_DHI0:   d = {24'h00_0000, unit_data_high_r[0]};
            `CCPTR_OFS_UCTRL1: d = {24'h00_0000, unit_control_reg_r[1]};
            `CCPTR_OFS_DLO1:   d = {24'h00_0000, unit_data_low_r[1]};
            `CCPTR_OFS_DHI1:   d = {24'h00_0000, unit_data_high_r[1]};
            `CCPTR_OFS_T3CTL:  d = {24'h00_0000, third_timer_control_r};
            `CCPTR_OFS_T1CTL:  d = {24'h00_0000, first_timer_ctrl_r};
            `CCPTR_OFS_T2CTL:  d = {24'h00_0000, second_timer_ctrl_r};
            `CCPTR_OFS_T2PER:  d = {24'h00_0000, second_timer_period_r};
            `CCPTR_OFS_CFG:    d = {24'h00_0000, cfg_r};
            `CCPTR_OFS_T1CNT:  d = {16'h0000, first_timer_r};
            `CCPTR_OFS_T3CNT:  d = {16'h0000, third_timer_r};
            `CCPTR_OFS_T2CNT:  d = {24'h00_0000, second_timer_r};
            default:           d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    assign hreadyout_o           = hreadyout_r;
    assign hresp_o               = 1'b0;
    assign hrdata_o              = hrdata_r;
    assign first_unit_pin_o      = out_r[0];
    assign first_unit_pin_oe_o   = oe_r[0];
    assign adc_start_o           = adc_start_r;
    assign second_timer_period_o = t2_wrap_r;

    assign pinsel   = cfg_r[`CCPTR_BIT_PINSEL];
    assign ext_edge = pin_sync_r[3] & ~pin_last_r[3];
    assign wr_go    = wr_pend_r & hready_i;

    always_comb begin
        for (int u = 0; u < 2; u++) begin
            cls[u]      = mode_class(unit_control_reg_r[u]);
            on_third[u] = uses_third(u, third_timer_control_r[`CCPTR_BIT_SEL_HI:`CCPTR_BIT_SEL_LO]);
            tbase[u]    = on_third[u] ? third_timer_r : first_timer_r;
            match_now[u] = (cls[u] == CCPTR_CMP) &&
                           (tbase[u] == {unit_data_high_r[u], unit_data_low_r[u]});
            match_new[u] = match_now[u] & ~match_r[u];
        end
        // Second unit input follows the selected pin
        pin_in[0] = pin_sync_r[0];
        pin_in[1] = pinsel ? pin_sync_r[1] : pin_sync_r[2];
        for (int u = 0; u < 2; u++) begin
            cap_evt[u] = 1'b0;
            if (cls[u] == CCPTR_CAPT) begin
                if (unit_control_reg_r[u][0]) begin
                    cap_evt[u] = pin_in[u] & ~pin_last_r[u == 0 ? 0 : (pinsel ? 1 : 2)];
                end else begin
                    cap_evt[u] = ~pin_in[u] & pin_last_r[u == 0 ? 0 : (pinsel ? 1 : 2)];
                end
                // Asynchronous count cannot be sampled safely, so the capture is dropped
                if (!on_third[u] && first_timer_ctrl_r[`CCPTR_BIT_ASYNC]) begin
                    cap_evt[u] = 1'b0;
                end
            end
        end
    end

    // Only the second flip-flop and its delayed copy feed logic
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
            pin_last_r <= 4'h0;
        end else begin
            pin_meta_r <= {first_timer_ext_clk_i, port_b_line_three_i,
                           port_c_line_one_i, first_unit_pin_i};
            pin_sync_r <= pin_meta_r;
            pin_last_r <= pin_sync_r;
        end
    end

    // AHB-Lite slave: writes take no wait state, reads take one so data is registered
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_pend_r   <= 1'b0;
            wr_pend_r   <= 1'b0;
            addr_r      <= 8'h00;
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h0000_0000;
        end else begin
            if (rd_pend_r) begin
                hrdata_r    <= read_mux(addr_r);
                hreadyout_r <= 1'b1;
                rd_pend_r   <= 1'b0;
            end else if (hready_i) begin
                wr_pend_r <= 1'b0;
                if (hsel_i && htrans_i[1]) begin
                    addr_r <= haddr_i[7:0];
                    if (hwrite_i) begin
                        wr_pend_r <= 1'b1;
                    end else begin
                        rd_pend_r   <= 1'b1;
                        hreadyout_r <= 1'b0;
                    end
                end
            end
        end
    end

    // Shared configuration registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            third_timer_control_r <= `CCPTR_RST_BYTE;
            first_timer_ctrl_r    <= `CCPTR_RST_BYTE;
            second_timer_ctrl_r   <= `CCPTR_RST_BYTE;
            second_timer_period_r <= `CCPTR_RST_T2PER;
            cfg_r                 <= `CCPTR_RST_CFG;
        end else if (wr_go) begin
            unique case (addr_r)
                `CCPTR_OFS_T3CTL: third_timer_control_r <= hwdata_i[7:0];
                `CCPTR_OFS_T1CTL: first_timer_ctrl_r    <= hwdata_i[7:0];
                `CCPTR_OFS_T2CTL: second_timer_ctrl_r   <= hwdata_i[7:0];
                `CCPTR_OFS_T2PER: second_timer_period_r <= hwdata_i[7:0];
                `CCPTR_OFS_CFG:   cfg_r                 <= hwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // Per-unit control and data bytes; hardware capture beats a software byte write
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int u = 0; u < 2; u++) begin
                unit_control_reg_r[u] <= `CCPTR_RST_BYTE;
                unit_data_low_r[u]    <= `CCPTR_RST_BYTE;
                unit_data_high_r[u]   <= `CCPTR_RST_BYTE;
            end
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (wr_go && addr_r == (u == 0 ? `CCPTR_OFS_UCTRL0 : `CCPTR_OFS_UCTRL1)) begin
                    // Writing 0 to the flag clears it, but a new event still sets it
                    unit_control_reg_r[u] <= {(hwdata_i[`CCPTR_BIT_FLAG] &
                                               unit_control_reg_r[u][`CCPTR_BIT_FLAG]) |
                                              cap_evt[u] | match_new[u],
                                              hwdata_i[6:0]};
                end else if (cap_evt[u] | match_new[u]) begin
                    unit_control_reg_r[u][`CCPTR_BIT_FLAG] <= 1'b1;
                end
                if (cap_evt[u]) begin
                    unit_data_low_r[u]  <= tbase[u][7:0];
                    unit_data_high_r[u] <= tbase[u][15:8];
                end else if (cls[u] == CCPTR_PWM && t2_wrap_r) begin
                    // Duty shadow reloads on the common period boundary
                    unit_data_high_r[u] <= unit_data_low_r[u];
                end else if (wr_go) begin
                    if (addr_r == (u == 0 ? `CCPTR_OFS_DLO0 : `CCPTR_OFS_DLO1)) begin
                        unit_data_low_r[u] <= hwdata_i[7:0];
                    end
                    if (addr_r == (u == 0 ? `CCPTR_OFS_DHI0 : `CCPTR_OFS_DHI1)) begin
                        unit_data_high_r[u] <= hwdata_i[7:0];
                    end
                end
            end
        end
    end

    // Compare match tracking and special event trigger
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            match_r     <= 2'b00;
            sev_r       <= 2'b00;
            sev_third_r <= 2'b00;
            adc_start_r <= 1'b0;
        end else begin
            match_r <= match_now;
            for (int u = 0; u < 2; u++) begin
                sev_r[u]       <= match_new[u] &&
                                  unit_control_reg_r[u][3:0] == `CCPTR_MODE_CSEV;
                sev_third_r[u] <= on_third[u];
            end
            adc_start_r <= match_new[1] &&
                           unit_control_reg_r[1][3:0] == `CCPTR_MODE_CSEV;
        end
    end

    // First and third timers; a trigger from either unit clears the timer it ran on
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            first_timer_r <= 16'h0000;
            third_timer_r <= 16'h0000;
        end else begin
            if ((sev_r[0] & ~sev_third_r[0]) | (sev_r[1] & ~sev_third_r[1])) begin
                first_timer_r <= 16'h0000;
            end else if (first_timer_ctrl_r[`CCPTR_BIT_ON]) begin
                if (!first_timer_ctrl_r[`CCPTR_BIT_ASYNC] || ext_edge) begin
                    first_timer_r <= first_timer_r + 16'h0001;
                end
            end
            if ((sev_r[0] & sev_third_r[0]) | (sev_r[1] & sev_third_r[1])) begin
                third_timer_r <= 16'h0000;
            end else if (third_timer_control_r[`CCPTR_BIT_ON]) begin
                third_timer_r <= third_timer_r + 16'h0001;
            end
        end
    end

    // Second timer: one period for every PWM unit
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            second_timer_r <= 8'h00;
            t2_wrap_r      <= 1'b0;
        end else begin
            t2_wrap_r <= 1'b0;
            if (second_timer_ctrl_r[`CCPTR_BIT_ON]) begin
                if (second_timer_r == second_timer_period_r) begin
                    second_timer_r <= 8'h00;
                    t2_wrap_r      <= 1'b1;
                end else begin
                    second_timer_r <= second_timer_r + 8'h01;
                end
            end
        end
    end

    // Unit pin drive
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            out_r <= 2'b00;
            oe_r  <= 2'b00;
        end else begin
            for (int u = 0; u < 2; u++) begin
                oe_r[u] <= (cls[u] == CCPTR_PWM) ||
                           ((cls[u] == CCPTR_CMP) &&
                            unit_control_reg_r[u][3:0] != `CCPTR_MODE_CSOFT &&
                            unit_control_reg_r[u][3:0] != `CCPTR_MODE_CSEV);
                if (cls[u] == CCPTR_PWM) begin
                    // Duty compares against the period timer only
                    out_r[u] <= second_timer_ctrl_r[`CCPTR_BIT_ON] &&
                                (second_timer_r < unit_data_high_r[u]);
                end else if (match_new[u]) begin
                    unique case (unit_control_reg_r[u][3:0])
                        `CCPTR_MODE_CSET: out_r[u] <= 1'b1;
                        `CCPTR_MODE_CCLR: out_r[u] <= 1'b0;
                        `CCPTR_MODE_CTOG: out_r[u] <= ~out_r[u];
                        default:          out_r[u] <= out_r[u];
                    endcase
                end else if (cls[u] == CCPTR_OFF) begin
                    out_r[u] <= 1'b0;
                end
            end
        end
    end

    // Second unit pin routing; only the selected pin gets the unit's output and enable, the other pin's enable is held low
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            port_c_line_one_o      <= 1'b0;
            port_c_line_one_oe_o   <= 1'b0;
            port_b_line_three_o    <= 1'b0;
            port_b_line_three_oe_o <= 1'b0;
        end else begin
            port_c_line_one_o      <= pinsel & out_r[1];
            port_c_line_one_oe_o   <= pinsel & oe_r[1];
            port_b_line_three_o    <= ~pinsel & out_r[1];
            port_b_line_three_oe_o <= ~pinsel & oe_r[1];
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, haddr_i[31:8], hsize_i, htrans_i[0], hwdata_i[31:8]};
endmodule
`default_nettype wire

// file: src/ccptr_params.svh
// Register offsets, field positions, reset values and codes for the unit timer resource block
//
// Contract
// - Each unit has a readable and writable control register and a data register made of 8-bit low and high bytes.
// - Capture and compare use the first or third timer as time base, PWM uses only the second timer.
// - The timer feeding each unit is picked by the timer-to-unit enable bits in the third timer control register.
// - Both units work at once and may share one timer when both are capture/compare or both are PWM.
// - With the first timer in asynchronous counter mode, captures against it are not taken.
// - The second unit's pin is port C line one when the pin select bit is 1, else port B line three.
// - Two capturing units have different time bases only with the first unit on the first timer and the second on the third.
// - A comparing unit can issue a special event trigger that resets its own time base timer.
// - The second unit's compare trigger event can also start an analog-to-digital conversion.
// - A compare reset of a shared timer also moves the time base of the other unit that captures on it.
// - Two PWM units share one period and one update moment, both from the second timer.
`ifndef CCPTR_PARAMS_SVH
`define CCPTR_PARAMS_SVH

`define CCPTR_OFS_UCTRL0   8'h00
`define CCPTR_OFS_DLO0     8'h04
`define CCPTR_OFS_DHI0     8'h08
`define CCPTR_OFS_UCTRL1   8'h0C
`define CCPTR_OFS_DLO1     8'h10
`define CCPTR_OFS_DHI1     8'h14
`define CCPTR_OFS_T3CTL    8'h18
`define CCPTR_OFS_T1CTL    8'h1C
`define CCPTR_OFS_T2CTL    8'h20
`define CCPTR_OFS_T2PER    8'h24
`define CCPTR_OFS_CFG      8'h28
`define CCPTR_OFS_T1CNT    8'h2C
`define CCPTR_OFS_T3CNT    8'h30
`define CCPTR_OFS_T2CNT    8'h34

`define CCPTR_BIT_ON       0
`define CCPTR_BIT_ASYNC    1
`define CCPTR_BIT_SEL_LO   1
`define CCPTR_BIT_SEL_HI   2
`define CCPTR_BIT_PINSEL   0
`define CCPTR_BIT_FLAG     7

`define CCPTR_MODE_CAPF    4'h4
`define CCPTR_MODE_CAPR    4'h5
`define CCPTR_MODE_CTOG    4'h2
`define CCPTR_MODE_CSET    4'h8
`define CCPTR_MODE_CCLR    4'h9
`define CCPTR_MODE_CSOFT   4'hA
`define CCPTR_MODE_CSEV    4'hB

`define CCPTR_RST_CFG      8'h01
`define CCPTR_RST_T2PER    8'hFF
`define CCPTR_RST_BYTE     8'h00

`endif

// file: src/ccptr_pkg.sv
// Types shared by the unit timer resource block
`default_nettype none
package ccptr_pkg;
    typedef enum logic [1:0] {
        CCPTR_OFF,
        CCPTR_CAPT,
        CCPTR_CMP,
        CCPTR_PWM
    } ccptr_class_t;

    typedef logic [7:0]  ccptr_byte_t;
    typedef logic [15:0] ccptr_word_t;
endpackage
`default_nettype wire

// file: verif/ccptr_props.sv
// Port-level assertions for the unit timer resource block
`default_nettype none
module ccptr_props (
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic       hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic       hwrite_i,
    input wire logic       hready_i,
    input wire logic       hreadyout_o,
    input wire logic       hresp_o,
    input wire logic       adc_start_o,
    input wire logic       second_timer_period_o,
    input wire logic       first_unit_pin_oe_o,
    input wire logic       port_c_line_one_oe_o,
    input wire logic       port_b_line_three_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic take_rd;
    logic take_wr;
    assign take_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    assign take_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    resp_okay_a: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    read_wait_a: assert property (take_rd |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    write_nowait_a: assert property (take_wr |=> hreadyout_o)
        else $error("write stalled");
    wait_cause_a: assert property ($fell(hreadyout_o) |-> $past(take_rd))
        else $error("wait state without read");
    adc_pulse_a: assert property (adc_start_o |=> !adc_start_o)
        else $error("conversion start longer than one cycle");
    period_pulse_a: assert property (second_timer_period_o |=> !second_timer_period_o)
        else $error("period pulse longer than one cycle");
    pin_route_a: assert property (!(port_c_line_one_oe_o && port_b_line_three_oe_o))
        else $error("second unit drives both pins");
    reset_state_a: assert property ($fell(rst_i) |-> hreadyout_o && !adc_start_o
        && !first_unit_pin_oe_o && !port_c_line_one_oe_o && !port_b_line_three_oe_o)
        else $error("outputs not idle after reset");
    read_c: cover property (take_rd ##1 !hreadyout_o);
    adc_c: cover property (adc_start_o);
    period_c: cover property (second_timer_period_o);
    altpin_c: cover property (port_b_line_three_oe_o);
endmodule
bind ccptr_top ccptr_props i_ccptr_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .adc_start_o(adc_start_o),
    .second_timer_period_o(second_timer_period_o),
    .first_unit_pin_oe_o(first_unit_pin_oe_o),
    .port_c_line_one_oe_o(port_c_line_one_oe_o),
    .port_b_line_three_oe_o(port_b_line_three_oe_o));
`default_nettype wire

// file: verif/ccptr_pins_model.sv
// Port pins and external count clock seen by the block
`default_nettype none
module ccptr_pins_model (
    input  wire logic lvl1_i,
    input  wire logic lvl2_i,
    input  wire logic ext_i,
    input  wire logic p1_o_i,
    input  wire logic p1_oe_i,
    input  wire logic pc_o_i,
    input  wire logic pc_oe_i,
    input  wire logic pb_o_i,
    input  wire logic pb_oe_i,
    output logic      p1_pin_o,
    output logic      pc_pin_o,
    output logic      pb_pin_o,
    output logic      ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Direction is left to the block's enables; selection turns a pin round through them
    assign p1_pin_o  = p1_oe_i ? p1_o_i : lvl1_i;
    assign pc_pin_o  = pc_oe_i ? pc_o_i : lvl2_i;
    assign pb_pin_o  = pb_oe_i ? pb_o_i : lvl2_i;
    assign ext_clk_o = ext_i;
endmodule
`default_nettype wire

// file: verif/ccp_timer_resource_config_test.sv
// Self-checking bench for the unit timer resource block
`default_nettype none
module ccp_timer_resource_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, hsel, hwrite, lvl1, lvl2, ext;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, hi;
    logic        hrdy, hresp, p1o, p1oe, pco, pcoe, pbo, pboe, adc, per;
    logic        p1i, pci, pbi, exti;
    int          failures, checks, n;
    ccptr_top i_ccptr_top (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
        .first_unit_pin_i(p1i), .first_unit_pin_o(p1o), .first_unit_pin_oe_o(p1oe),
        .port_c_line_one_i(pci), .port_c_line_one_o(pco), .port_c_line_one_oe_o(pcoe),
        .port_b_line_three_i(pbi), .port_b_line_three_o(pbo),
        .port_b_line_three_oe_o(pboe), .first_timer_ext_clk_i(exti),
        .adc_start_o(adc), .second_timer_period_o(per));
    ccptr_pins_model i_ccptr_pins_model (.lvl1_i(lvl1), .lvl2_i(lvl2), .ext_i(ext),
        .p1_o_i(p1o), .p1_oe_i(p1oe), .pc_o_i(pco), .pc_oe_i(pcoe), .pb_o_i(pbo),
        .pb_oe_i(pboe), .p1_pin_o(p1i), .pc_pin_o(pci), .pb_pin_o(pbi), .ext_clk_o(exti));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= 1'b1;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk); while (hrdy !== 1'b1);
    endtask
    task automatic rdw(input logic [7:0] a, output logic [31:0] v);
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= 1'b0;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        do @(posedge clk); while (hrdy !== 1'b1);
        v = hrdata;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic t_regs();
        rdw(8'h28, rd); chk(rd, 32'h0000_0001);
        rdw(8'h24, rd); chk(rd, 32'h0000_00FF);
        rdw(8'h00, rd); chk(rd, 32'h0000_0000);
        for (int i = 0; i < 6; i++) wr(8'(4 * i), 8'(16 * (i + 1)));
        for (int i = 0; i < 6; i++) begin
            rdw(8'(4 * i), rd); chk(rd, 32'(16 * (i + 1)));
        end
        wr(8'h2C, 8'h55);
        rdw(8'h2C, rd); chk(rd, 32'h0000_0000);
        rdw(8'h3C, rd); chk(rd, 32'h0000_0000);
    endtask
    task automatic t_compare_pin();
        wr(8'h28, 8'h00); wr(8'h10, 8'h40); wr(8'h14, 8'h00); wr(8'h0C, 8'h08);
        // First unit toggles on the same timer, later than the second unit sets
        wr(8'h04, 8'h50); wr(8'h08, 8'h00); wr(8'h00, 8'h02);
        wr(8'h1C, 8'h01);
        chk({pboe, pbo, pcoe}, 32'h0000_0004);
        n = 0;
        while (pbo !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk({pboe, pbo, pcoe}, 32'h0000_0006);
        rdw(8'h2C, rd); chk(32'(rd >= 32'h40), 32'h1);
        rdw(8'h0C, rd); chk(rd, 32'h0000_0088);
        n = 0;
        while (p1o !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk({p1oe, p1o}, 32'h0000_0003);
    endtask
    task automatic t_special_event();
        wr(8'h28, 8'h01); wr(8'h00, 8'h05); wr(8'h10, 8'h00); wr(8'h14, 8'h01);
        wr(8'h0C, 8'h0B);
        n = 0;
        while (adc !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk(adc, 32'h1);
        rdw(8'h2C, rd); chk(32'(rd < 32'h20), 32'h1);
        lvl1 <= 1'b1;
        cycles(6);
        rdw(8'h04, rd);
        rdw(8'h08, hi);
        chk(32'(rd + {hi[23:0], 8'h00} < 32'h60), 32'h1);
        rdw(8'h0C, rd); chk(rd, 32'h0000_008B);
    endtask
    task automatic t_capture();
        wr(8'h18, 8'h02); wr(8'h00, 8'h04); wr(8'h0C, 8'h05);
        lvl1 <= 1'b0;
        lvl2 <= 1'b0;
        cycles(5);
        lvl1 <= 1'b1;
        lvl2 <= 1'b1;
        cycles(6);
        rdw(8'h04, rd); chk(32'(rd != 0), 32'h1);
        rdw(8'h10, rd); chk(rd, 32'h0000_0000);
        rdw(8'h14, rd); chk(rd, 32'h0000_0000);
        rdw(8'h0C, rd); chk(rd, 32'h0000_0085);
        rdw(8'h00, rd); chk(rd, 32'h0000_0084);
    endtask
    task automatic t_async();
        wr(8'h1C, 8'h03); wr(8'h00, 8'h05);
        lvl1 <= 1'b0;
        cycles(5);
        lvl1 <= 1'b1;
        ext  <= 1'b1;
        cycles(6);
        rdw(8'h00, rd); chk(rd, 32'h0000_0005);
    endtask
    task automatic t_pwm();
        wr(8'h28, 8'h00); wr(8'h24, 8'h0F); wr(8'h04, 8'h04); wr(8'h10, 8'h08);
        wr(8'h00, 8'h0C); wr(8'h0C, 8'h0C); wr(8'h20, 8'h01);
        for (int k = 0; k < 2; k++) do @(posedge clk); while (per !== 1'b1);
        n = 0;
        hi = 0;
        rd = 0;
        // One full period after the duty took effect, so any start phase counts the same
        do begin
            @(posedge clk);
            n++;
            rd = rd + 32'(p1o);
            hi = hi + 32'(pbo);
        end while (per !== 1'b1 && n < 40);
        chk(32'(n), 32'h0000_0010);
        chk(rd, 32'h0000_0004);
        chk(hi, 32'h0000_0008);
        rdw(8'h14, rd); chk(rd, 32'h0000_0008);
    endtask
    initial begin
        failures = 0;
        checks = 0;
        rst = 1'b1;
        hsel = 1'b1;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
        lvl1 = 1'b0;
        lvl2 = 1'b0;
        ext = 1'b0;
        cycles(8);
        rst <= 1'b0;
        cycles(1);
        t_regs();
        t_compare_pin();
        t_special_event();
        t_capture();
        t_async();
        t_pwm();
        tally_and_finish();
    end
    initial begin
        #200us;
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
